// [src/sch_pkg.sv]
// package for the scanner channel handshake block
package sch_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CHAN_W = 8;
  localparam logic [CHAN_W-1:0] CHAN_RST = 8'h00;
  localparam int unsigned START_DLY_US = 350;
  localparam int unsigned COMPARE_US = 1000;
  localparam int unsigned DISPLAY_US = 10000;
  localparam int unsigned CMP_DISP_US = 4500;
  localparam int unsigned START_DLY_CYC = START_DLY_US * CLK_MHZ;
  localparam int unsigned COMPARE_CYC = COMPARE_US * CLK_MHZ;
  localparam int unsigned DISPLAY_CYC = DISPLAY_US * CLK_MHZ;
  localparam int unsigned CMP_DISP_CYC = CMP_DISP_US * CLK_MHZ;
  localparam int unsigned MEAS_CYC_DEF = 1000 * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;

  typedef enum logic [2:0] {
    SCH_IDLE = 3'b000,
    SCH_DELAY = 3'b001,
    SCH_MEAS = 3'b010,
    SCH_POST = 3'b011
  } sch_state_t;
endpackage

// [src/sch_tmr_if.sv]
// interface between the sequencer and its phase timer
`timescale 1ns/100ps
interface sch_tmr_if;
  import sch_pkg::*;
  logic load;
  logic [CNT_W-1:0] len;
  logic done;
  modport ctrl (output load, output len, input done);
  modport tmr (input load, input len, output done);
endinterface

// [src/sch_timer.sv]
// down counter timing each measurement phase
`timescale 1ns/100ps
module sch_timer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  sch_tmr_if.tmr t
);
  import sch_pkg::*;
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic done;
  } sch_tmr_st_t;
  sch_tmr_st_t st_r;
  sch_tmr_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (t.load) begin
      st_nxt.cnt = t.len;
    end else if (st_r.cnt != CNT_ZERO) begin
      st_nxt.cnt = st_r.cnt - CNT_ONE;
      st_nxt.done = (st_r.cnt == CNT_ONE);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign t.done = st_r.done;
endmodule // sch_timer

// [src/sch_handshake.sv]
// meter side of the scanner channel handshake
// Functional notes
// - on trigger, capture channel number and measure with its correction data; here only while strobe is low, else the last channel is kept.
// - measurement begins typically 350 us after trigger.
// - after end-of-measurement, meter accepts the next trigger.
// - correction data switch adds no time, inside settling.
// - comparison takes about 1 ms before end-of-measurement.
// - display update takes about 10 ms per page before end-of-measurement.
// - combined comparison and display interval is about 4.5 ms.
// - slash-named signals are active low, others active high.
// - analog-complete asserts when analog measurement finishes.
// - end-of-measurement asserts only when data and comparison are valid.
// - in external trigger mode, start on trigger rising edge.
`timescale 1ns/100ps
module sch_handshake #(
  parameter int unsigned START_CYC = sch_pkg::START_DLY_CYC,
  parameter int unsigned MEAS_CYC = sch_pkg::MEAS_CYC_DEF,
  parameter int unsigned POST_CYC = sch_pkg::CMP_DISP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_trigger_in_mode,
  input wire logic i_ext_trigger_in,
  input wire logic [sch_pkg::CHAN_W-1:0] i_chan_sel_n,
  input wire logic i_chan_strobe_n,
  output logic o_meas_busy,
  output logic [sch_pkg::CHAN_W-1:0] o_corr_chan,
  output logic o_corr_load,
  output logic o_meas_done_n,
  output logic o_meas_end_n
);
  import sch_pkg::*;

  typedef struct packed {
    sch_state_t state;
    logic trig_d;
    logic [CHAN_W-1:0] chan;
    logic corr_load;
    logic busy;
    logic done_n;
    logic end_n;
    logic [CNT_W-1:0] ph_cyc;
  } sch_st_t;
  sch_st_t st_r;
  sch_st_t st_nxt;
  logic tmr_load;
  logic [CNT_W-1:0] tmr_len;

  sch_tmr_if tif ();
  assign tif.load = tmr_load;
  assign tif.len = tmr_len;

  sch_timer u_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .t(tif.tmr)
  );

  // fit a cycle count into the timer width
  function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
    cyc = CNT_W'(n);
  endfunction

  wire trig_rise = i_ext_trigger_in && !st_r.trig_d;

  always_comb begin
    st_nxt = st_r;
    st_nxt.trig_d = i_ext_trigger_in;
    st_nxt.corr_load = 1'b0;
    tmr_load = 1'b0;
    tmr_len = CNT_ZERO;
    unique case (st_r.state)
      SCH_IDLE: begin
        // edges in other modes are ignored and the sequencer stays idle
        if (i_ext_trigger_in_mode && trig_rise) begin
          if (!i_chan_strobe_n) begin
            st_nxt.chan = ~i_chan_sel_n;
          end
          st_nxt.end_n = 1'b1;
          st_nxt.busy = 1'b1;
          st_nxt.state = SCH_DELAY;
          tmr_load = 1'b1;
          tmr_len = cyc(START_CYC);
        end
      end
      SCH_DELAY: begin
        if (tif.done) begin
          st_nxt.corr_load = 1'b1;
          st_nxt.state = SCH_MEAS;
          tmr_load = 1'b1;
          tmr_len = cyc(MEAS_CYC);
        end
      end
      SCH_MEAS: begin
        if (tif.done) begin
          st_nxt.done_n = 1'b0;
          st_nxt.state = SCH_POST;
          tmr_load = 1'b1;
          tmr_len = cyc(POST_CYC);
        end
      end
      SCH_POST: begin
        if (tif.done) begin
          // analog-complete withdrawn with the end flag so the scanner may release
          st_nxt.done_n = 1'b1;
          st_nxt.end_n = 1'b0;
          st_nxt.busy = 1'b0;
          st_nxt.state = SCH_IDLE;
        end
      end
      default: st_nxt.state = SCH_IDLE;
    endcase
    // phase age, read only by the length checks; drops out of synthesis
    if (st_nxt.state != st_r.state || st_r.state == SCH_IDLE) begin
      st_nxt.ph_cyc = CNT_ZERO;
    end else begin
      st_nxt.ph_cyc = st_r.ph_cyc + CNT_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '{state: SCH_IDLE, trig_d: 1'b1, chan: CHAN_RST, corr_load: 1'b0,
                busy: 1'b0, done_n: 1'b1, end_n: 1'b1, ph_cyc: CNT_ZERO};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_meas_busy = st_r.busy;
  assign o_corr_chan = st_r.chan;
  assign o_corr_load = st_r.corr_load;
  assign o_meas_done_n = st_r.done_n;
  assign o_meas_end_n = st_r.end_n;

  // lengths are held against the phase age, not against the timer that makes them
  trig_capture_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_IDLE && i_ext_trigger_in_mode && trig_rise && !i_chan_strobe_n
    |=> o_corr_chan == ~$past(i_chan_sel_n)) else $error("channel not captured");
  strobe_ignore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_chan_strobe_n |=> o_corr_chan == $past(o_corr_chan))
    else $error("channel taken without strobe");
  rise_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_IDLE && !(i_ext_trigger_in_mode && trig_rise) |=> st_r.state == SCH_IDLE)
    else $error("start without rising edge");
  start_delay_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_meas_busy) |-> !o_corr_load [*2])
    else $error("measurement started early");
  done_order_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_meas_done_n) |-> o_meas_end_n && o_meas_busy)
    else $error("analog done out of order");
  end_after_done_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_meas_end_n) |-> !$past(o_meas_done_n))
    else $error("end without analog done");
  end_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_meas_end_n |-> !o_meas_busy && st_r.state == SCH_IDLE)
    else $error("not ready after end");
  corr_load_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_corr_load |-> st_r.state == SCH_MEAS && o_meas_done_n)
    else $error("correction load misplaced");
  post_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $fell(o_meas_done_n) |-> o_meas_end_n [*2])
    else $error("post phase too short");
  start_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_DELAY && tif.done |-> st_r.ph_cyc == cyc(START_CYC))
    else $error("start delay length wrong");
  meas_len_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_MEAS && tif.done |-> st_r.ph_cyc == cyc(MEAS_CYC))
    else $error("measurement length wrong");
  post_cyc_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_POST && tif.done |-> st_r.ph_cyc == cyc(POST_CYC))
    else $error("compare and display length wrong");
  busy_chan_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_meas_busy |=> $stable(o_corr_chan))
    else $error("channel changed mid measurement");
  chan_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !(st_r.state == SCH_IDLE && i_ext_trigger_in_mode && trig_rise) |=> $stable(o_corr_chan))
    else $error("channel changed without trigger");
  busy_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_meas_busy == (st_r.state != SCH_IDLE))
    else $error("busy out of step with sequencer");
  out_excl_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_meas_end_n |-> o_meas_done_n)
    else $error("analog done still low at end");
  done_post_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_meas_done_n |-> st_r.state == SCH_POST && o_meas_busy)
    else $error("analog done outside compare phase");
  done_rise_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(o_meas_done_n) |-> !o_meas_end_n)
    else $error("analog done withdrawn early");
  end_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_meas_end_n && !(i_ext_trigger_in_mode && trig_rise) |=> !o_meas_end_n)
    else $error("end flag dropped without trigger");
  delay_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_DELAY |-> o_meas_done_n && o_meas_end_n && !o_corr_load)
    else $error("outputs active before start");
  meas_quiet_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_MEAS |-> o_meas_done_n && o_meas_end_n && o_meas_busy)
    else $error("outputs active during measurement");
  post_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_POST |-> !o_meas_done_n && o_meas_end_n)
    else $error("analog done not held in compare phase");
  load_once_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_corr_load |=> !o_corr_load)
    else $error("correction load held");
  rst_out_a: assert property (@(posedge i_clk)
    !i_rst_n |=> !o_meas_busy && !o_corr_load && o_meas_done_n && o_meas_end_n && o_corr_chan == CHAN_RST)
    else $error("outputs not idle after reset");

  // start, analog done, end, trigger without strobe, trigger in another mode
  trig_cov_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_meas_busy));
  done_cov_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(o_meas_done_n));
  end_cov_c: cover property (@(posedge i_clk) disable iff (!i_rst_n) $fell(o_meas_end_n));
  nostrobe_cov_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    st_r.state == SCH_IDLE && i_ext_trigger_in_mode && trig_rise && i_chan_strobe_n);
  refused_cov_c: cover property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_ext_trigger_in_mode && trig_rise);
endmodule // sch_handshake

// [tb/sch_scanner.sv]
// scanner model driving channel, strobe and trigger pins
`timescale 1ns/100ps
module sch_scanner #(
  parameter int unsigned TRIG_CYC = 250
) (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_chan,
  input wire logic i_valid,
  input wire logic i_meas_done_n,
  output logic [7:0] o_chan_sel_n,
  output logic o_chan_strobe_n,
  output logic o_ext_trigger_in
);
  int unsigned cnt = 0;
  logic done_q = 1'b1;
  logic [7:0] sel_n_q = 8'hFF;
  logic strb_n_q = 1'b1;
  logic trig_q = 1'b0;
  always @(posedge i_clk) begin
    done_q <= i_meas_done_n;
    // one low cycle first, so a pulse still high gives a fresh edge
    trig_q <= (cnt != 0) && (cnt <= TRIG_CYC);
    if (i_go) begin
      // a new channel wins over a release in the same cycle
      sel_n_q <= ~i_chan;
      strb_n_q <= ~i_valid;
      cnt <= TRIG_CYC + 1;
    end else begin
      if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      // released pins float to the pull-up level
      if (i_meas_done_n && !done_q) begin
        sel_n_q <= 8'hFF;
        strb_n_q <= 1'b1;
      end
    end
  end
  assign o_chan_sel_n = sel_n_q;
  assign o_chan_strobe_n = strb_n_q;
  assign o_ext_trigger_in = trig_q;
endmodule // sch_scanner

// [tb/tb_scanner_channel_handshake.sv]
// testbench for the scanner channel handshake
`timescale 1ns/100ps
module tb_scanner_channel_handshake;
  import sch_pkg::*;
  localparam int ST = 4, MC = 6, PC = 5;
  logic i_clk = 1'b0, i_rst_n = 1'b0, mode = 1'b1, go = 1'b0, vld = 1'b0;
  logic [7:0] chan = 8'h00, sel_n;
  logic strb_n, trig, busy, load, done_n, end_n;
  logic [CHAN_W-1:0] corr;
  int failures = 0, cmp_count = 0;
  sch_scanner sch_scanner_i (.i_clk(i_clk), .i_go(go), .i_chan(chan), .i_valid(vld), .i_meas_done_n(done_n),
    .o_chan_sel_n(sel_n), .o_chan_strobe_n(strb_n), .o_ext_trigger_in(trig));
  sch_handshake #(.START_CYC(ST), .MEAS_CYC(MC), .POST_CYC(PC)) sch_handshake_i (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_ext_trigger_in_mode(mode), .i_ext_trigger_in(trig), .i_chan_sel_n(sel_n),
    .i_chan_strobe_n(strb_n), .o_meas_busy(busy), .o_corr_chan(corr), .o_corr_load(load),
    .o_meas_done_n(done_n), .o_meas_end_n(end_n));
  initial forever #2 i_clk = ~i_clk;
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    chk_val(got[7:0], exp[7:0]);
  endtask
  // bounded wait, n counts edges until the event
  task automatic wait_ev(input int k, output int n);
    logic hit;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
      case (k)
        0: hit = busy === 1'b1;
        1: hit = load === 1'b1;
        2: hit = done_n === 1'b0;
        default: hit = end_n === 1'b0;
      endcase
    end while (!hit && n < 200);
  endtask
  task automatic measure(input logic [7:0] c, input logic v, input logic [7:0] exp_c);
    int n;
    @(posedge i_clk);
    chan <= c;
    vld <= v;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    wait_ev(0, n);
    chk_val(end_n, 1'b1);
    wait_ev(1, n);
    // each phase lasts its count plus the edge that hands over to the next
    chk_cnt(n, ST + 1);
    chk_val(corr, exp_c);
    wait_ev(2, n);
    chk_cnt(n, MC + 1);
    chk_val(end_n, 1'b1);
    wait_ev(3, n);
    chk_cnt(n, PC + 1);
    chk_val({busy, done_n}, 2'b01);
  endtask
  task automatic sc_first();
    measure(8'h00, 1'b1, 8'h00);
  endtask
  task automatic sc_back();
    measure(8'h7F, 1'b1, 8'h7F);
  endtask
  task automatic sc_hold();
    measure(8'h55, 1'b0, 8'h7F);
  endtask
  task automatic sc_off();
    int n;
    @(posedge i_clk);
    mode <= 1'b0;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    wait_ev(0, n);
    chk_cnt(n, 200);
    @(posedge i_clk);
    mode <= 1'b1;
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk_val({busy, load, done_n, end_n}, 4'b0011);
    chk_val(corr, CHAN_RST);
    sc_first();
    sc_back();
    sc_off();
    sc_hold();
    test_done();
  end
  initial begin
    repeat (3000) @(posedge i_clk);
    failures++;
    test_done();
  end
endmodule // tb_scanner_channel_handshake
